// [duart_sig.sv]
// duart_sig.sv: ready pins, interrupt pins and write steering for both channels of a dual uart
// assumes fifo levels and status come from same-clock datapath logic; bus strobes arrive async
`timescale 1ns/1ns
`include "duart_sig_regs.svh"
module duart_sig #(
  parameter int DEPTH = `DUART_FIFO_DEPTH,
  parameter int LW = $clog2(DEPTH + 1)
) (
  input wire logic core_clk_in, // 10 mhz clock
  input wire logic rst_n_in, // async reset, low
  input wire logic chip_select_n_in, // host select, pin
  input wire logic channel_select_in, // 1 = channel a, pin
  input wire logic write_n_in, // host write strobe, pin
  input wire logic [7:0] afr_in, // alternate function register (shared)
  input wire logic [7:0] fcr_a_in, // fifo control register a
  input wire logic [7:0] fcr_b_in, // fifo control register b
  input wire logic [7:0] feat_a_in, // feature control register a
  input wire logic [7:0] feat_b_in, // feature control register b
  input wire logic [LW-1:0] rx_lvl_a_in, // receive fifo level a
  input wire logic [LW-1:0] rx_lvl_b_in, // receive fifo level b
  input wire logic [LW-1:0] tx_lvl_a_in, // transmit fifo level a
  input wire logic [LW-1:0] tx_lvl_b_in, // transmit fifo level b
  input wire logic [LW-1:0] rx_trig_a_in, // receive trigger a
  input wire logic [LW-1:0] rx_trig_b_in, // receive trigger b
  input wire logic [LW-1:0] tx_trig_a_in, // transmit trigger a
  input wire logic [LW-1:0] tx_trig_b_in, // transmit trigger b
  input wire logic [1:0] rx_timeout_in, // receive timeout pulse, bit0 = a
  input wire logic [1:0] tsr_empty_in, // shift register empty, bit0 = a
  output logic wr_a_out, // write pulse to channel a
  output logic wr_b_out, // write pulse to channel b
  output logic [1:0] multifunction_pin_out, // receive_ready_n or high, bit0 = a
  output logic [1:0] transmit_ready_n_out, // bit0 = a
  output logic [1:0] receive_ready_n_out, // bit0 = a
  output logic channel_a_irq_out, // low = service needed
  output logic channel_b_irq_out // low = service needed
);
  initial begin
    if (DEPTH < 2 || LW < $clog2(DEPTH + 1)) $error("duart_sig: bad fifo depth or level width");
  end

  // ==========================================================
  // host strobe synchronisers
  // bus cycles need no oscillator; sampling here only times steering pulses
  logic [2:0] bus_s1_r, bus_s2_r, bus_s1_nxt, bus_s2_nxt;
  logic wr_seen_r, wr_seen_nxt;
  logic wr_a_r, wr_b_r, wr_a_nxt, wr_b_nxt;
  logic wr_go;

  always_comb begin
    bus_s1_nxt = {chip_select_n_in, channel_select_in, write_n_in};
    bus_s2_nxt = bus_s1_r;
    // selected write edge: chip select low and write low
    wr_go = !bus_s2_r[2] && !bus_s2_r[0];
    wr_seen_nxt = wr_go;
    wr_a_nxt = 1'b0;
    wr_b_nxt = 1'b0;
    if (wr_go && !wr_seen_r) begin
      if (afr_in[`DUART_AFR_BCAST_BIT]) begin
        wr_a_nxt = 1'b1;
        wr_b_nxt = 1'b1;
      end else begin
        wr_a_nxt = bus_s2_r[1];
        wr_b_nxt = !bus_s2_r[1];
      end
    end
  end

  // strobe registers
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_s1_r <= 3'h7;
      bus_s2_r <= 3'h7;
      wr_seen_r <= 1'b0;
      wr_a_r <= 1'b0;
      wr_b_r <= 1'b0;
    end else begin
      bus_s1_r <= bus_s1_nxt;
      bus_s2_r <= bus_s2_nxt;
      wr_seen_r <= wr_seen_nxt;
      wr_a_r <= wr_a_nxt;
      wr_b_r <= wr_b_nxt;
    end
  end

  // ==========================================================
  // per-channel pin logic
  logic [LW-1:0] rx_lvl [2];
  logic [LW-1:0] tx_lvl [2];
  logic [LW-1:0] rx_trig [2];
  logic [LW-1:0] tx_trig [2];
  logic [7:0] fifo_control_register [2];
  logic [7:0] feat [2];
  logic [1:0] rxr_r, rxr_nxt, txr_r, txr_nxt, mf_r, mf_nxt, irq_r, irq_nxt;
  duart_sig_pkg::duart_mode_t mode [2];
  logic [1:0] rs485;
  logic [1:0] rx_int, tx_int;

  // gather channel inputs into arrays
  always_comb begin
    rx_lvl[0] = rx_lvl_a_in;
    rx_lvl[1] = rx_lvl_b_in;
    tx_lvl[0] = tx_lvl_a_in;
    tx_lvl[1] = tx_lvl_b_in;
    rx_trig[0] = rx_trig_a_in;
    rx_trig[1] = rx_trig_b_in;
    tx_trig[0] = tx_trig_a_in;
    tx_trig[1] = tx_trig_b_in;
    fifo_control_register[0] = fcr_a_in;
    fifo_control_register[1] = fcr_b_in;
    feat[0] = feat_a_in;
    feat[1] = feat_b_in;
  end

  // next pin values for both channels
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      // mode decode from fifo control
      if (!fifo_control_register[c][`DUART_FCR_EN_BIT]) mode[c] = duart_sig_pkg::DUART_MODE_NOFIFO;
      else if (fifo_control_register[c][`DUART_FCR_BLOCK_BIT]) mode[c] = duart_sig_pkg::DUART_MODE_BLOCK;
      else mode[c] = duart_sig_pkg::DUART_MODE_SINGLE;
      // feature register resets to 0 so direction control starts off
      rs485[c] = feat[c][`DUART_FEAT_RS485_BIT];
      rxr_nxt[c] = rxr_r[c];
      txr_nxt[c] = 1'b1;
      unique case (mode[c])
        duart_sig_pkg::DUART_MODE_NOFIFO: begin
          rxr_nxt[c] = (rx_lvl[c] == '0); // holding register empty reads as high
          txr_nxt[c] = (tx_lvl[c] != '0);
        end
        duart_sig_pkg::DUART_MODE_SINGLE: begin
          rxr_nxt[c] = (rx_lvl[c] == '0);
          txr_nxt[c] = (tx_lvl[c] != '0);
        end
        duart_sig_pkg::DUART_MODE_BLOCK: begin
          // falls at trigger or timeout, rises on empty, else holds
          if (rx_lvl[c] == '0) rxr_nxt[c] = 1'b1;
          else if (rx_lvl[c] >= rx_trig[c] || rx_timeout_in[c]) rxr_nxt[c] = 1'b0;
          txr_nxt[c] = (tx_lvl[c] == LW'(DEPTH));
        end
      endcase
      // multifunction pin as receive ready only for code 10
      if (afr_in[`DUART_AFR_MF_HI:`DUART_AFR_MF_LO] == `DUART_AFR_MF_RECEIVE_READY_N) mf_nxt[c] = rxr_nxt[c];
      else mf_nxt[c] = 1'b1;
      // transmit interrupt condition, active low
      if (mode[c] == duart_sig_pkg::DUART_MODE_NOFIFO) tx_int[c] = (tx_lvl[c] != '0);
      else tx_int[c] = (tx_lvl[c] > tx_trig[c]) && (tx_lvl[c] != '0);
      // rs-485: stay low until the shift register has drained too
      if (rs485[c] && !tx_int[c] && tx_lvl[c] == '0 && !tsr_empty_in[c]) tx_int[c] = 1'b1;
      else if (rs485[c] && !tx_int[c] && tx_lvl[c] != '0) tx_int[c] = 1'b1;
      // receive interrupt: fifo on, low below trigger, high at or above; fifo off, always high
      if (mode[c] == duart_sig_pkg::DUART_MODE_NOFIFO) rx_int[c] = 1'b1;
      else rx_int[c] = (rx_lvl[c] >= rx_trig[c]);
      // pin low when transmit needs service or receive is below trigger
      irq_nxt[c] = !tx_int[c] && rx_int[c];
    end
  end

  // pin registers
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rxr_r <= 2'h3;
      txr_r <= 2'h0;
      mf_r <= 2'h3;
      irq_r <= 2'h3;
    end else begin
      rxr_r <= rxr_nxt;
      txr_r <= txr_nxt;
      mf_r <= mf_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign wr_a_out = wr_a_r;
  assign wr_b_out = wr_b_r;
  assign multifunction_pin_out = mf_r;
  assign transmit_ready_n_out = txr_r;
  assign receive_ready_n_out = rxr_r;
  assign channel_a_irq_out = irq_r[0];
  assign channel_b_irq_out = irq_r[1];
endmodule // duart_sig

// [duart_sig_regs.svh]
// duart_sig_regs.svh: field positions, reset values and sizes for the dual uart pin-signalling block
// assumes inclusion by bare name from the top module
// Summary of operation
// - A host write while the broadcast bit of the alternate function register is set goes to both channels and channel_select is ignored.
// - The multifunction pin carries receive_ready_n only while alternate function bits [2:1] equal 10.
// - With fifos on, fifo control bit 3 picks single-character signalling at 0 and block mode at 1.
// - Fifo on, block mode off: receive_ready_n is low while the receive fifo holds a byte, high when empty.
// - Block mode: receive_ready_n falls at trigger level or timeout and rises when the receive fifo empties.
// - Fifo off: transmit_ready_n is low while transmit_holding is empty, high while a byte waits.
// - Fifo on, block mode off: transmit_ready_n is low only when the transmit fifo is empty.
// - Block mode: transmit_ready_n is low while the transmit fifo has a free place, high only when full.
// - Without rs-485 mode the transmit interrupt is low with a byte held or fifo above trigger, else high.
// - In rs-485 mode the transmit interrupt goes high only when the whole transmitter is empty.
// - With the fifo on, the receive interrupt is low below the trigger level and high above it.
// - The oscillator clock feeds both baud generators and host bus cycles need no clock.
// - The device is selected only while chip_select_n is 0; channel_select 1 picks channel a, 0 picks b.
// - Auto rs-485 direction control is off after reset and turns on only when feature bit 3 is set.
`ifndef DUART_SIG_REGS_SVH
`define DUART_SIG_REGS_SVH
// alternate function register fields
`define DUART_AFR_BCAST_BIT 0
`define DUART_AFR_MF_LO 1
`define DUART_AFR_MF_HI 2
`define DUART_AFR_MF_RECEIVE_READY_N 2'h2
// fifo control register fields
`define DUART_FCR_EN_BIT 0
`define DUART_FCR_BLOCK_BIT 3
// feature control register fields
`define DUART_FEAT_RS485_BIT 3
// reset values and fifo depth
`define DUART_AFR_RST 8'h00
`define DUART_FCR_RST 8'h00
`define DUART_FEAT_RST 8'h00
`define DUART_FIFO_DEPTH 128
`endif

// [duart_sig_pkg.sv]
// duart_sig_pkg.sv: types shared by the dual uart pin-signalling block
// assumes the constants header sits in the same folder
package duart_sig_pkg;
  // signalling mode of one channel's ready pins
  typedef enum logic [1:0] {
    DUART_MODE_NOFIFO,
    DUART_MODE_SINGLE,
    DUART_MODE_BLOCK
  } duart_mode_t;
endpackage

// [duart_sig_assertions.sv]
// duart_sig_assertions.sv: pin and strobe checks on channel a of duart_sig
// assumes a bind from the bench top; inputs are same-clock levels
`timescale 1ns/1ns
module duart_sig_assertions #(parameter int DEPTH = 128, parameter int LW = 8) (
  input wire logic core_clk_in, rst_n_in, chip_select_n_in, // clock, reset, select
  input wire logic [7:0] afr_in, fcr_a_in, feat_a_in, // control registers
  input wire logic [LW-1:0] rx_lvl_a_in, tx_lvl_a_in, rx_trig_a_in, tx_trig_a_in, // levels
  input wire logic wr_a_out, channel_a_irq_out, // write pulse, irq
  input wire logic [1:0] multifunction_pin_out, transmit_ready_n_out, receive_ready_n_out // pins
);
  // up_r masks the first edge after reset, before outputs follow inputs
  logic up_r;
  logic up_nxt;
  logic en;
  logic bk;
  assign en = fcr_a_in[0];
  assign bk = fcr_a_in[0] & fcr_a_in[3];
  always_comb up_nxt = 1'b1;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) up_r <= 1'b0;
    else up_r <= up_nxt;
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================
  // pin relations, one cycle after their inputs; write pulse three cycles after select
  a_rx_single: assert property (up_r && $past(en && !bk) |->
    receive_ready_n_out[0] == ($past(rx_lvl_a_in) == 0)) else $error("rx ready single wrong");
  a_rx_block: assert property (up_r && $past(bk && rx_lvl_a_in >= rx_trig_a_in && rx_lvl_a_in != 0) |->
    !receive_ready_n_out[0]) else $error("rx ready block wrong");
  a_tx_nofifo: assert property (up_r && $past(!en) |->
    transmit_ready_n_out[0] == ($past(tx_lvl_a_in) != 0)) else $error("tx ready nofifo wrong");
  a_tx_single: assert property (up_r && $past(en && !bk) |->
    transmit_ready_n_out[0] == ($past(tx_lvl_a_in) != 0)) else $error("tx ready single wrong");
  a_tx_block: assert property (up_r && $past(bk) |->
    transmit_ready_n_out[0] == ($past(tx_lvl_a_in) == DEPTH)) else $error("tx ready block wrong");
  a_mf_pin: assert property (up_r |-> multifunction_pin_out ==
    ($past(afr_in[2:1]) == 2'h2 ? receive_ready_n_out : 2'h3)) else $error("mf pin wrong");
  a_irq_plain: assert property (up_r && $past(!feat_a_in[3]) |-> channel_a_irq_out ==
    !$past(en ? (tx_lvl_a_in > tx_trig_a_in || rx_lvl_a_in < rx_trig_a_in) : tx_lvl_a_in != 0))
    else $error("irq a wrong");
  a_wr_select: assert property (wr_a_out |-> $past(!chip_select_n_in, 3))
    else $error("write without select");
endmodule // duart_sig_assertions

// [duart_sig_host.sv]
// duart_sig_host.sv: host cpu model making write cycles on the async bus
// assumes the bench clock; released select line shows the inverse channel
`timescale 1ns/1ns
module duart_sig_host (
  input wire logic clk_in, // bench clock
  output logic chip_select_n_out = 1'b1, // host select
  output logic channel_select_out = 1'b0, // 1 = channel a
  output logic write_n_out = 1'b1 // write strobe
);
  // one write, strobe held 6 edges, then 4 idle edges
  task automatic wr_cycle(input logic cs_n, input logic ch);
    @(posedge clk_in);
    chip_select_n_out <= cs_n;
    channel_select_out <= ch;
    write_n_out <= 1'b0;
    repeat (6) @(posedge clk_in);
    chip_select_n_out <= 1'b1;
    channel_select_out <= !ch;
    write_n_out <= 1'b1;
    repeat (4) @(posedge clk_in);
  endtask
endmodule // duart_sig_host

// [duart_sig_bench.sv]
// duart_sig_bench.sv: self-checking bench for duart_sig with fifo depth 8
// assumes duart_sig_host drives the bus pins; both channels share stimulus
`timescale 1ns/1ns
module duart_sig_bench;
  localparam int DEPTH = 8;
  localparam int LW = 4;
  logic clk, rst_n, to, ts, cs_n, ch, write_n, wa, wb, ia, ib;
  logic [7:0] alternate_function_register, fifo_control_register, feat;
  logic [LW-1:0] rl, rt, tl, tt;
  logic [1:0] mf, txr, rxr;
  int num_errors = 0, check_count = 0, na = 0, nb = 0;
  duart_sig #(.DEPTH(DEPTH)) duart_sig_i (.core_clk_in(clk), .rst_n_in(rst_n), .chip_select_n_in(cs_n),
    .channel_select_in(ch), .write_n_in(write_n), .afr_in(alternate_function_register), .fcr_a_in(fifo_control_register), .fcr_b_in(fifo_control_register), .feat_a_in(feat),
    .feat_b_in(feat), .rx_lvl_a_in(rl), .rx_lvl_b_in(rl), .tx_lvl_a_in(tl), .tx_lvl_b_in(tl), .rx_trig_a_in(rt),
    .rx_trig_b_in(rt), .tx_trig_a_in(tt), .tx_trig_b_in(tt), .rx_timeout_in({2{to}}), .tsr_empty_in({2{ts}}),
    .wr_a_out(wa), .wr_b_out(wb), .multifunction_pin_out(mf), .transmit_ready_n_out(txr),
    .receive_ready_n_out(rxr), .channel_a_irq_out(ia), .channel_b_irq_out(ib));
  duart_sig_host duart_sig_host_i (.clk_in(clk), .chip_select_n_out(cs_n), .channel_select_out(ch),
    .write_n_out(write_n));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // count write pulses per channel
  always @(posedge clk) begin
    na <= na + int'(wa === 1'b1);
    nb <= nb + int'(wb === 1'b1);
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // apply fcr and levels, let them settle, compare ready, irq and mf pins
  task automatic pin(input logic [7:0] f, input logic [LW-1:0] a, b, c, d, input logic er, et, ei);
    @(posedge clk);
    fifo_control_register <= f;
    rl <= a;
    rt <= b;
    tl <= c;
    tt <= d;
    repeat (3) @(posedge clk);
    #1;
    chk("rx_ready", rxr, {2{er}});
    chk("tx_ready", txr, {2{et}});
    chk("irq", {ib, ia}, {2{ei}});
    chk("mf", mf, alternate_function_register[2:1] == 2'h2 ? {2{er}} : 2'h3);
    // back onto the rising edge so later stimulus lands there
    @(posedge clk);
  endtask
  // one host write, then compare pulse totals
  task automatic wcheck(input logic c, input logic h, input int ea, input int eb);
    duart_sig_host_i.wr_cycle(c, h);
    chk("wr_a", 8'(na), 8'(ea));
    chk("wr_b", 8'(nb), 8'(eb));
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    conclude();
  end
  initial begin
    {rst_n, to, ts, fifo_control_register, feat, rl, rt, tl, tt} = '0;
    alternate_function_register = 8'h04;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    pin(8'h00, 1, 1, 0, 1, 0, 0, 1);
    pin(8'h00, 1, 1, 1, 1, 0, 1, 0);
    pin(8'h01, 0, 2, 0, 4, 1, 0, 0);
    pin(8'h01, 1, 1, 3, 4, 0, 1, 1);
    pin(8'h01, 3, 2, 5, 4, 0, 1, 0);
    pin(8'h09, 0, 4, 7, 8, 1, 0, 0);
    pin(8'h09, 2, 4, 7, 8, 1, 0, 0);
    pin(8'h09, 4, 4, 8, 8, 0, 1, 1);
    pin(8'h09, 2, 4, 7, 8, 0, 0, 0);
    pin(8'h09, 0, 4, 7, 8, 1, 0, 0);
    rl <= 1;
    to <= 1'b1;
    @(posedge clk);
    to <= 1'b0;
    pin(8'h09, 1, 4, 7, 8, 0, 0, 0);
    alternate_function_register <= 8'h02;
    pin(8'h01, 1, 1, 0, 1, 0, 0, 1);
    feat <= 8'h08;
    pin(8'h00, 0, 1, 1, 1, 1, 1, 0);
    pin(8'h00, 0, 1, 0, 1, 1, 0, 0);
    ts <= 1'b1;
    pin(8'h00, 0, 1, 0, 1, 1, 0, 1);
    alternate_function_register <= 8'h00;
    wcheck(1'b0, 1'b1, 1, 0);
    wcheck(1'b0, 1'b0, 1, 1);
    alternate_function_register <= 8'h01;
    wcheck(1'b0, 1'b0, 2, 2);
    wcheck(1'b1, 1'b1, 2, 2);
    conclude();
  end
endmodule // duart_sig_bench
bind duart_sig duart_sig_assertions #(.DEPTH(DEPTH), .LW(LW)) duart_sig_assertions_i (.core_clk_in(core_clk_in),
  .rst_n_in(rst_n_in), .chip_select_n_in(chip_select_n_in), .afr_in(afr_in), .fcr_a_in(fcr_a_in),
  .feat_a_in(feat_a_in), .rx_lvl_a_in(rx_lvl_a_in), .tx_lvl_a_in(tx_lvl_a_in), .rx_trig_a_in(rx_trig_a_in),
  .tx_trig_a_in(tx_trig_a_in), .wr_a_out(wr_a_out), .channel_a_irq_out(channel_a_irq_out),
  .multifunction_pin_out(multifunction_pin_out), .transmit_ready_n_out(transmit_ready_n_out),
  .receive_ready_n_out(receive_ready_n_out));
